// file: rtl/ccr_pkg.sv
// Constants shared by the configuration control register bank.
// Assumes an 8-bit I/O data path and byte-wide register indexes.
package ccr_pkg;
  // I/O ports for index selection and data transfer.
  localparam logic [15:0] IDX_PORT = 16'h0022;
  localparam logic [15:0] DATA_PORT = 16'h0023;
  // Register indexes.
  localparam logic [7:0] IDX_CTRL0 = 8'hC0;
  localparam logic [7:0] IDX_CTRL1 = 8'hC1;
  localparam logic [7:0] IDX_CTRL2 = 8'hC2;
  // Field positions, first control register.
  localparam int B0_UNCACHED = 1;
  // Field positions, second control register.
  localparam int B1_SMM_PIN = 1;
  localparam int B1_SMM_MEM = 2;
  localparam int B1_NO_LOCK = 4;
  localparam int B1_SMM_REGION = 7;
  // Field positions, third control register.
  localparam int B2_SLOW_ADS = 1;
  localparam int B2_NW_LOCK = 2;
  localparam int B2_SUSPEND_ON_HALT = 3;
  localparam int B2_WPROT = 4;
  localparam int B2_SUSPEND_REQUEST_INPUT_PIN = 7;
  // Implemented bits; all others are reserved and read as zero.
  localparam logic [7:0] MASK0 = 8'h02;
  localparam logic [7:0] MASK1 = 8'h96;
  localparam logic [7:0] MASK2 = 8'h9E;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Legacy region from 640 KB up to 1 MB.
  localparam logic [31:0] REGION_LO = 32'h000A_0000;
  localparam logic [31:0] REGION_END = 32'h0010_0000;
  // Idle level of the two active-low pins sampled here.
  localparam logic [1:0] PIN_IDLE = 2'h3;
endpackage : ccr_pkg

// file: rtl/ccr_ads_gap.sv
// Idle insertion between back-to-back non-pipelined bus cycles.
// Assumes cycleDone marks the sampled burst ready of a cycle's last transfer.
`timescale 1ns/1ns
`default_nettype none
module ccr_ads_gap (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic arst_n,
  // Control.
  input wire logic slowAds,
  // Bus sequencing.
  input wire logic cycleDone,
  input wire logic adsReq,
  output logic adsGo
);
  logic idle_q;
  logic idle_d;

  // One idle clock follows burst ready only in slow mode.
  assign idle_d = cycleDone & slowAds;
  assign adsGo = adsReq & ~idle_q;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      idle_q <= 1'b0;
    end else begin
      idle_q <= idle_d;
    end
  end

  property p_slow_gap;
    @(posedge ref_clk) disable iff (!arst_n)
    (cycleDone && slowAds) |=> !adsGo;
  endproperty
  a_slow_gap: assert property (p_slow_gap) else $error("Strobe issued without idle clock.");

  property p_fast_gap;
    @(posedge ref_clk) disable iff (!arst_n)
    (!slowAds && !$past(slowAds)) |-> (adsGo == adsReq);
  endproperty
  a_fast_gap: assert property (p_fast_gap) else $error("Idle clock inserted in fast mode.");
endmodule : ccr_ads_gap
`default_nettype wire

// file: rtl/ccr_regs.sv
// Bank of the first three configuration control registers and the logic they steer.
// Assumes core, cache and bus logic share ref_clk; only the two control pins are asynchronous.
`timescale 1ns/1ns
`default_nettype none
module ccr_regs (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic arst_n,
  // Configuration I/O port.
  input wire logic [15:0] ioAddr,
  input wire logic ioWrEn,
  input wire logic ioRdEn,
  input wire logic [7:0] ioWrData,
  output logic ioHit,
  output logic [7:0] ioRdData,
  output logic ioRdValid,
  // Memory access attributes.
  input wire logic [31:0] memAddr,
  input wire logic memCacheableIn,
  output logic regionNonCacheable,
  output logic regionWriteProtect,
  // System management.
  input wire logic smmIntIn_n,
  input wire logic smmRegion3Hit,
  input wire logic inSmmMode,
  output logic smiToCore,
  output logic smmActiveOut_n,
  output logic smmSpaceHit,
  output logic routeToSmmMemory,
  // Bus locking.
  input wire logic coreLockReq,
  input wire logic pageTableCycle,
  input wire logic intAckCycle,
  output logic lockOut_n,
  output logic executeLocked,
  output logic lockedCacheAllowed,
  // Bus cycle sequencing.
  input wire logic cycleDone,
  input wire logic adsReq,
  output logic adsGo,
  // Cache no-write bit.
  input wire logic nwWrEn,
  input wire logic nwWrData,
  output logic cacheNoWrite,
  // Suspend.
  input wire logic haltExec,
  input wire logic suspReqIn_n,
  input wire logic suspendedCore,
  output logic suspendEnter,
  output logic suspendReqToCore,
  output logic suspAckOut_n,
  output logic suspAckOe
);
  logic [7:0] ctrl0_q;
  logic [7:0] ctrl1_q;
  logic [7:0] ctrl2_q;
  logic [7:0] idx_q;
  logic idxValid_q;
  logic [7:0] rdData_q;
  logic rdValid_q;
  logic nw_q;
  logic suspEnter_q;
  logic [1:0] pinRaw;
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  logic [1:0] sync3_q;
  logic [1:0] pin_q;

  // Register fields.
  logic legacyRegionUncached;
  logic smmPinEnable;
  logic smmMemoryAccess;
  logic lockSuppress;
  logic smmRegionSelect;
  logic slowAddressStrobe;
  logic noWriteLock;
  logic suspendOnHalt;
  logic regionWriteProtectEn;
  logic suspendPinEnable;

  assign legacyRegionUncached = ctrl0_q[ccr_pkg::B0_UNCACHED];
  assign smmPinEnable = ctrl1_q[ccr_pkg::B1_SMM_PIN];
  assign smmMemoryAccess = ctrl1_q[ccr_pkg::B1_SMM_MEM];
  assign lockSuppress = ctrl1_q[ccr_pkg::B1_NO_LOCK];
  assign smmRegionSelect = ctrl1_q[ccr_pkg::B1_SMM_REGION];
  assign slowAddressStrobe = ctrl2_q[ccr_pkg::B2_SLOW_ADS];
  assign noWriteLock = ctrl2_q[ccr_pkg::B2_NW_LOCK];
  assign suspendOnHalt = ctrl2_q[ccr_pkg::B2_SUSPEND_ON_HALT];
  assign regionWriteProtectEn = ctrl2_q[ccr_pkg::B2_WPROT];
  assign suspendPinEnable = ctrl2_q[ccr_pkg::B2_SUSPEND_REQUEST_INPUT_PIN];

  // Port decode. Only these three indexes are answered here, and they need
  // no map enable, so nothing else gates them.
  logic idxPortWr;
  logic dataPortWr;
  logic dataPortRd;
  logic wrIdxOurs;
  logic dataHit;
  logic selCtrl0;
  logic selCtrl1;
  logic selCtrl2;
  logic [7:0] rdMux;

  assign idxPortWr = ioWrEn & (ioAddr == ccr_pkg::IDX_PORT);
  assign dataPortWr = ioWrEn & (ioAddr == ccr_pkg::DATA_PORT);
  assign dataPortRd = ioRdEn & (ioAddr == ccr_pkg::DATA_PORT);
  assign wrIdxOurs = (ioWrData == ccr_pkg::IDX_CTRL0) | (ioWrData == ccr_pkg::IDX_CTRL1) |
                     (ioWrData == ccr_pkg::IDX_CTRL2);
  assign dataHit = (dataPortWr | dataPortRd) & idxValid_q;
  // Reads of the index port always go out to the bus.
  assign ioHit = (idxPortWr & wrIdxOurs) | dataHit;
  assign selCtrl0 = idx_q == ccr_pkg::IDX_CTRL0;
  assign selCtrl1 = idx_q == ccr_pkg::IDX_CTRL1;
  assign selCtrl2 = idx_q == ccr_pkg::IDX_CTRL2;
  assign rdMux = selCtrl0 ? ctrl0_q : (selCtrl1 ? ctrl1_q : (selCtrl2 ? ctrl2_q : 8'h00));
  assign ioRdData = rdData_q;
  assign ioRdValid = rdValid_q;

  // Index selection. Every data port access consumes the selection, so a second
  // data access without a fresh index falls through to an external cycle.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      idx_q <= 8'h00;
      idxValid_q <= 1'b0;
    end else if (idxPortWr) begin
      idx_q <= ioWrData;
      idxValid_q <= wrIdxOurs;
    end else if (dataPortWr | dataPortRd) begin
      idxValid_q <= 1'b0;
    end
  end

  // Register writes store implemented bits only, so reserved bits read zero.
  logic wrCtrl0;
  logic wrCtrl1;
  logic wrCtrl2;
  assign wrCtrl0 = dataPortWr & idxValid_q & selCtrl0;
  assign wrCtrl1 = dataPortWr & idxValid_q & selCtrl1;
  assign wrCtrl2 = dataPortWr & idxValid_q & selCtrl2;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl0_q <= ccr_pkg::CTRL_RESET;
      ctrl1_q <= ccr_pkg::CTRL_RESET;
      ctrl2_q <= ccr_pkg::CTRL_RESET;
    end else begin
      if (wrCtrl0) begin
        ctrl0_q <= ioWrData & ccr_pkg::MASK0;
      end
      if (wrCtrl1) begin
        ctrl1_q <= ioWrData & ccr_pkg::MASK1;
      end
      if (wrCtrl2) begin
        ctrl2_q <= ioWrData & ccr_pkg::MASK2;
      end
    end
  end

  // Read data comes from a flop one clock after the request.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData_q <= 8'h00;
      rdValid_q <= 1'b0;
    end else begin
      rdValid_q <= dataPortRd & idxValid_q;
      if (dataPortRd & idxValid_q) begin
        rdData_q <= rdMux;
      end
    end
  end

  // Legacy region attributes.
  logic memInRegion;
  assign memInRegion = (memAddr >= ccr_pkg::REGION_LO) & (memAddr < ccr_pkg::REGION_END);
  assign regionNonCacheable = memInRegion & (legacyRegionUncached | ~memCacheableIn);
  assign regionWriteProtect = memInRegion & regionWriteProtectEn &
                              memCacheableIn & ~legacyRegionUncached;

  // Pin synchronisers: a level counts once the second and third stages agree.
  assign pinRaw = {suspReqIn_n, smmIntIn_n};
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gSync
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          sync1_q[g] <= ccr_pkg::PIN_IDLE[g];
          sync2_q[g] <= ccr_pkg::PIN_IDLE[g];
          sync3_q[g] <= ccr_pkg::PIN_IDLE[g];
          pin_q[g] <= ccr_pkg::PIN_IDLE[g];
        end else begin
          sync1_q[g] <= pinRaw[g];
          sync2_q[g] <= sync1_q[g];
          sync3_q[g] <= sync2_q[g];
          if (sync2_q[g] == sync3_q[g]) begin
            pin_q[g] <= sync3_q[g];
          end
        end
      end
    end
  endgenerate

  // System management. The region select is trusted to be set together with the
  // pin enable; without it no smm space exists and smm memory is never reached.
  assign smmSpaceHit = smmRegionSelect & smmRegion3Hit;
  assign routeToSmmMemory = smmSpaceHit & (smmMemoryAccess | inSmmMode);
  assign smiToCore = smmPinEnable & ~smmMemoryAccess & ~pin_q[0];
  assign smmActiveOut_n = ~(smmPinEnable & inSmmMode);

  // Bus locking.
  logic lockExempt;
  assign lockExempt = pageTableCycle | intAckCycle;
  assign lockOut_n = ~(coreLockReq & (~lockSuppress | pageTableCycle));
  assign executeLocked = coreLockReq & (~lockSuppress | lockExempt);
  assign lockedCacheAllowed = memCacheableIn & ~executeLocked;

  // Idle insertion before the next address strobe.
  ccr_ads_gap uAdsGap (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .slowAds(slowAddressStrobe),
    .cycleDone(cycleDone),
    .adsReq(adsReq),
    .adsGo(adsGo)
  );

  // Cache no-write bit; a locked bit drops writes without any error.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      nw_q <= 1'b0;
    end else if (nwWrEn & ~noWriteLock) begin
      nw_q <= nwWrData;
    end
  end
  assign cacheNoWrite = nw_q;

  // Suspend.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      suspEnter_q <= 1'b0;
    end else begin
      suspEnter_q <= haltExec & suspendOnHalt;
    end
  end
  assign suspendEnter = suspEnter_q;
  assign suspendReqToCore = suspendPinEnable & ~pin_q[1];
  assign suspAckOut_n = ~(suspendPinEnable & suspendedCore);
  assign suspAckOe = suspendPinEnable;

  // Checks.
  sequence s_sel_valid;
    idxPortWr && wrIdxOurs;
  endsequence

  sequence s_data_write;
    dataPortWr && !idxPortWr;
  endsequence

  property p_index_then_data;
    @(posedge ref_clk) disable iff (!arst_n)
    s_sel_valid ##1 s_data_write |-> ioHit ##1 !idxValid_q;
  endproperty
  a_index_then_data: assert property (p_index_then_data) else $error("Data access not answered.");

  property p_no_index;
    @(posedge ref_clk) disable iff (!arst_n)
    (dataPortRd && !idxValid_q) |-> !ioHit ##1 !ioRdValid;
  endproperty
  a_no_index: assert property (p_no_index) else $error("Unselected access answered.");

  property p_uncached;
    @(posedge ref_clk) disable iff (!arst_n)
    (memInRegion && legacyRegionUncached) |-> regionNonCacheable;
  endproperty
  a_uncached: assert property (p_uncached) else $error("Legacy region cached.");

  property p_smm_pins_off;
    @(posedge ref_clk) disable iff (!arst_n)
    !smmPinEnable |-> (smmActiveOut_n && !smiToCore);
  endproperty
  a_smm_pins_off: assert property (p_smm_pins_off) else $error("Smm pins active while off.");

  property p_smm_route;
    @(posedge ref_clk) disable iff (!arst_n)
    (smmMemoryAccess && smmSpaceHit) |-> routeToSmmMemory;
  endproperty
  a_smm_route: assert property (p_smm_route) else $error("Smm access not routed.");

  property p_smm_memory_access_masks;
    @(posedge ref_clk) disable iff (!arst_n)
    smmMemoryAccess |-> !smiToCore;
  endproperty
  a_smm_memory_access_masks: assert property (p_smm_memory_access_masks) else $error("Smi passed while masked.");

  property p_lock_neg;
    @(posedge ref_clk) disable iff (!arst_n)
    (lockSuppress && !pageTableCycle) |-> (lockOut_n && (executeLocked == (coreLockReq && intAckCycle)));
  endproperty
  a_lock_neg: assert property (p_lock_neg) else $error("Lock pin or lock state wrong.");

  property p_region3;
    @(posedge ref_clk) disable iff (!arst_n)
    smmSpaceHit |-> (smmRegionSelect && smmRegion3Hit);
  endproperty
  a_region3: assert property (p_region3) else $error("Smm space outside region three.");

  property p_nw_frozen;
    @(posedge ref_clk) disable iff (!arst_n)
    (nwWrEn && noWriteLock) |=> $stable(cacheNoWrite);
  endproperty
  a_nw_frozen: assert property (p_nw_frozen) else $error("Locked no-write bit changed.");

  property p_suspend_request_input_halt;
    @(posedge ref_clk) disable iff (!arst_n)
    haltExec |=> (suspendEnter == $past(suspendOnHalt));
  endproperty
  a_suspend_request_input_halt: assert property (p_suspend_request_input_halt) else $error("Halt suspend wrong.");

  property p_wprot;
    @(posedge ref_clk) disable iff (!arst_n)
    regionWriteProtect |-> (regionWriteProtectEn && memInRegion && memCacheableIn);
  endproperty
  a_wprot: assert property (p_wprot) else $error("Protection outside its region.");

  property p_suspend_request_input_pins;
    @(posedge ref_clk) disable iff (!arst_n)
    !suspendPinEnable |-> (!suspAckOe && !suspendReqToCore);
  endproperty
  a_suspend_request_input_pins: assert property (p_suspend_request_input_pins) else $error("Suspend pins used while off.");

  property p_reserved;
    @(posedge ref_clk) disable iff (!arst_n)
    ((ctrl0_q & ~ccr_pkg::MASK0) == 8'h00) && ((ctrl1_q & ~ccr_pkg::MASK1) == 8'h00);
  endproperty
  a_reserved: assert property (p_reserved) else $error("Reserved bit set.");
endmodule : ccr_regs
`default_nettype wire

// file: tb/ccr_chipset_model.sv
// Chipset model on the processor bus: drives the smm and suspend request pins.
// Assumes the bench sets smiWant and suspWant; the acknowledge pin has a pull-up.
`timescale 1ns/1ns
`default_nettype none
module ccr_chipset_model (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic arst_n,
  // Requests from the bench.
  input wire logic smiWant,
  input wire logic suspWant,
  // Pins.
  input wire logic suspAckOut_n,
  input wire logic suspAckOe,
  output logic smmIntIn_n,
  output logic suspReqIn_n,
  output logic suspAckSeen
);
  // Pins change just after an edge, as a synchronous chipset would drive them.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      smmIntIn_n <= 1'h1;
      suspReqIn_n <= 1'h1;
    end else begin
      smmIntIn_n <= !smiWant;
      suspReqIn_n <= !suspWant;
    end
  end
  // A released acknowledge pin is pulled up, so the chipset sees it inactive.
  assign suspAckSeen = suspAckOe ? !suspAckOut_n : 1'h0;
endmodule : ccr_chipset_model
`default_nettype wire

// file: tb/cpu_config_control_regs_bench.sv
// Self-checking bench for the configuration control register bank.
// Assumes ccr_regs as the top design module and the chipset model on the pins.
`timescale 1ns/1ns
`default_nettype none
module cpu_config_control_regs_bench;
  logic ref_clk = 1'h0;
  logic arst_n = 1'h0;
  logic [15:0] ioAddr = 16'h0000;
  logic [7:0] ioWrData = 8'h00;
  logic [31:0] memAddr = 32'h0000_0000;
  logic ioWrEn = 1'h0, ioRdEn = 1'h0, memCacheableIn = 1'h0, smmRegion3Hit = 1'h0;
  logic inSmmMode = 1'h0, coreLockReq = 1'h0, pageTableCycle = 1'h0, intAckCycle = 1'h0;
  logic cycleDone = 1'h0, adsReq = 1'h0, nwWrEn = 1'h0, nwWrData = 1'h0, haltExec = 1'h0;
  logic suspendedCore = 1'h0, smiWant = 1'h0, suspWant = 1'h0;
  logic smmIntIn_n, suspReqIn_n, suspAckSeen, ioHit, ioRdValid, regionNonCacheable;
  logic regionWriteProtect, smiToCore, smmActiveOut_n, smmSpaceHit, routeToSmmMemory;
  logic lockOut_n, executeLocked, lockedCacheAllowed, adsGo, cacheNoWrite, suspendEnter;
  logic suspendReqToCore, suspAckOut_n, suspAckOe;
  logic [7:0] ioRdData;
  logic [7:0] masks [3] = '{8'h02, 8'h96, 8'h9E};
  int fails = 0;
  int n_compared = 0;

  always #50 ref_clk = !ref_clk;

  ccr_regs dut (.ref_clk, .arst_n, .ioAddr, .ioWrEn, .ioRdEn, .ioWrData, .ioHit, .ioRdData,
    .ioRdValid, .memAddr, .memCacheableIn, .regionNonCacheable, .regionWriteProtect,
    .smmIntIn_n, .smmRegion3Hit, .inSmmMode, .smiToCore, .smmActiveOut_n, .smmSpaceHit,
    .routeToSmmMemory, .coreLockReq, .pageTableCycle, .intAckCycle, .lockOut_n,
    .executeLocked, .lockedCacheAllowed, .cycleDone, .adsReq, .adsGo, .nwWrEn, .nwWrData,
    .cacheNoWrite, .haltExec, .suspReqIn_n, .suspendedCore, .suspendEnter,
    .suspendReqToCore, .suspAckOut_n, .suspAckOe);
  ccr_chipset_model chipset (.ref_clk, .arst_n, .smiWant, .suspWant, .suspAckOut_n,
    .suspAckOe, .smmIntIn_n, .suspReqIn_n, .suspAckSeen);

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One port access; strobes drop a full cycle later, so calls never collide.
  task automatic ioAcc(input logic [15:0] a, input logic wr, input logic [7:0] d,
                       input logic hit);
    @(negedge ref_clk);
    ioAddr = a;
    ioWrEn = wr;
    ioRdEn = !wr;
    ioWrData = d;
    #1 check(ioHit, hit);
    @(negedge ref_clk);
    ioWrEn = 1'h0;
    ioRdEn = 1'h0;
  endtask : ioAcc

  task automatic regWr(input logic [7:0] idx, input logic [7:0] d);
    ioAcc(ccr_pkg::IDX_PORT, 1'h1, idx, 1'h1);
    ioAcc(ccr_pkg::DATA_PORT, 1'h1, d, 1'h1);
  endtask : regWr

  task automatic regRd(input logic [7:0] idx, input logic [7:0] exp);
    ioAcc(ccr_pkg::IDX_PORT, 1'h1, idx, 1'h1);
    ioAcc(ccr_pkg::DATA_PORT, 1'h0, 8'h00, 1'h1);
    check(ioRdValid, 8'h01);
    check(ioRdData, exp);
  endtask : regRd

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  // The whole sequence needs well under a thousand cycles.
  initial begin
    repeat (3000) @(posedge ref_clk);
    fails++;
    final_report();
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    arst_n = 1'h1;
    for (int i = 0; i < 3; i++) begin
      regRd(ccr_pkg::IDX_CTRL0 + 8'(i), 8'h00);
      regWr(ccr_pkg::IDX_CTRL0 + 8'(i), 8'hFF);
      regRd(ccr_pkg::IDX_CTRL0 + 8'(i), masks[i]);
      regWr(ccr_pkg::IDX_CTRL0 + 8'(i), 8'h00);
    end
    // Refused accesses go external and change nothing.
    ioAcc(ccr_pkg::IDX_PORT, 1'h0, 8'h00, 1'h0);
    ioAcc(ccr_pkg::DATA_PORT, 1'h0, 8'h00, 1'h0);
    ioAcc(ccr_pkg::IDX_PORT, 1'h1, 8'hD0, 1'h0);
    ioAcc(ccr_pkg::DATA_PORT, 1'h1, 8'h02, 1'h0);
    regRd(ccr_pkg::IDX_CTRL0, 8'h00);
    memAddr = 32'h000A_0000;
    memCacheableIn = 1'h1;
    #1 check(regionNonCacheable, 8'h00);
    regWr(ccr_pkg::IDX_CTRL0, 8'h02);
    #1 check(regionNonCacheable, 8'h01);
    memAddr = 32'h0010_0000;
    #1 check(regionNonCacheable, 8'h00);
    regWr(ccr_pkg::IDX_CTRL0, 8'h00);
    regWr(ccr_pkg::IDX_CTRL2, 8'h10);
    memAddr = 32'h000F_FFFF;
    #1 check(regionWriteProtect, 8'h01);
    memAddr = 32'h0010_0000;
    #1 check(regionWriteProtect, 8'h00);
    coreLockReq = 1'h1;
    #1 check(lockOut_n, 8'h00);
    regWr(ccr_pkg::IDX_CTRL1, 8'h10);
    #1 check(lockOut_n, 8'h01);
    check(executeLocked, 8'h00);
    check(lockedCacheAllowed, 8'h01);
    intAckCycle = 1'h1;
    #1 check(lockOut_n, 8'h01);
    check(executeLocked, 8'h01);
    intAckCycle = 1'h0;
    pageTableCycle = 1'h1;
    #1 check(lockOut_n, 8'h00);
    coreLockReq = 1'h0;
    smiWant = 1'h1;
    inSmmMode = 1'h1;
    smmRegion3Hit = 1'h1;
    regWr(ccr_pkg::IDX_CTRL1, 8'h00);
    repeat (5) @(negedge ref_clk);
    check(smiToCore, 8'h00);
    check(smmActiveOut_n, 8'h01);
    check(smmSpaceHit, 8'h00);
    regWr(ccr_pkg::IDX_CTRL1, 8'h82);
    check(smiToCore, 8'h01);
    check(smmActiveOut_n, 8'h00);
    check(smmSpaceHit, 8'h01);
    inSmmMode = 1'h0;
    regWr(ccr_pkg::IDX_CTRL1, 8'h86);
    check(smiToCore, 8'h00);
    check(routeToSmmMemory, 8'h01);
    smiWant = 1'h0;
    adsReq = 1'h1;
    for (int s = 0; s < 2; s++) begin
      regWr(ccr_pkg::IDX_CTRL2, (s == 0) ? 8'h02 : 8'h00);
      cycleDone = 1'h1;
      @(negedge ref_clk);
      cycleDone = 1'h0;
      check(adsGo, 8'(s));
      regWr(ccr_pkg::IDX_CTRL2, (s == 0) ? 8'h0C : 8'h00);
      // Always try to set the bit, so the locked pass shows a dropped write.
      nwWrEn = 1'h1;
      nwWrData = 1'h1;
      haltExec = 1'h1;
      @(negedge ref_clk);
      nwWrEn = 1'h0;
      haltExec = 1'h0;
      check(suspendEnter, 8'(1 - s));
      check(cacheNoWrite, 8'(s));
    end
    suspWant = 1'h1;
    suspendedCore = 1'h1;
    repeat (5) @(negedge ref_clk);
    check(suspendReqToCore, 8'h00);
    check(suspAckSeen, 8'h00);
    regWr(ccr_pkg::IDX_CTRL2, 8'h80);
    check(suspendReqToCore, 8'h01);
    check(suspAckOe, 8'h01);
    check(suspAckSeen, 8'h01);
    // A reset in mid-run must clear what software wrote before it.
    @(negedge ref_clk);
    arst_n = 1'h0;
    repeat (2) @(negedge ref_clk);
    arst_n = 1'h1;
    check(cacheNoWrite, 8'h00);
    check(suspAckOe, 8'h00);
    check(suspendReqToCore, 8'h00);
    regRd(ccr_pkg::IDX_CTRL1, 8'h00);
    regRd(ccr_pkg::IDX_CTRL2, 8'h00);
    final_report();
  end
endmodule : cpu_config_control_regs_bench
`default_nettype wire
